// *** run_cmd_ctrl.v ***
// run-command qualification, trip handling and auto restart with apb registers
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "run_cmd_defines.vh"
module run_cmd_ctrl
(
  input  wire        CLK,
  input  wire        SRST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        FWD_IN,
  input  wire        REV_IN,
  input  wire        KEY_RUN,
  input  wire        KEY_STOP,
  input  wire        SER_RUN,
  input  wire        SER_REV,
  input  wire        FAULT,
  input  wire        TRIP_RESET,
  output reg         DRIVE_ON,
  output reg         DRIVE_REV,
  output reg         SPEED_SEARCH,
  output reg         IRQ
);
  // binary state codes, copied straight into the status word
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_RUN  = 2'd1;
  localparam [1:0] ST_TRIP = 2'd2;
  localparam [1:0] ST_WAIT = 2'd3;
  // 100 ms delay unit
  localparam [19:0] TICK_CYC = 20'd1000000;

  reg  [1:0]  fwd_s_q;
  reg  [1:0]  rev_s_q;
  reg  [1:0]  flt_s_q;
  reg  [1:0]  trs_s_q;
  reg  [1:0]  krun_s_q;
  reg  [1:0]  kstp_s_q;
  reg  [2:0]  src_q;
  reg  [1:0]  inhibit_q;
  reg         pwr_run_q;
  reg         trip_restart_enable_q;
  reg  [7:0]  speed_search_options_q;
  reg  [7:0]  station_id_setting_q;
  reg  [3:0]  restart_attempt_limit_q;
  reg  [15:0] restart_delay_setting_q;
  reg         direction_command_param_q;
  reg  [3:0]  attempts_q;
  reg  [19:0] tick_q;
  reg  [15:0] delay_q;
  reg  [1:0]  state_q;
  reg         armed_q;
  reg         key_latch_q;
  reg  [3:0]  irq_stat_q;
  reg  [3:0]  irq_mask_q;
  reg         trip_prev_q;
  reg  [1:0]  state_d;
  reg         want_run;
  reg         want_rev;
  reg  [3:0]  ev;
  wire        fwd;
  wire        rev;
  wire        flt;
  wire        trs;
  wire        terminal_src;
  wire        wr;
  wire        rd;
  wire        bad_dir;
  wire        src_change;
  wire        pwrup_arm;


  function inhibited;
    input [1:0] inh;
    input       dir_rev;
    begin
      inhibited = (inh == `INH_FWD && !dir_rev) ||
                  (inh == `INH_REV && dir_rev);
    end
  endfunction

  // used only by the bus error flag; the read mux relies on its default arm
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `A_CTRL) || (a == `A_STATION) ||
               (a == `A_RESTART) || (a == `A_STATUS) ||
               (a == `A_IRQ_STAT) || (a == `A_IRQ_MASK) ||
               (a == `A_DIRCMD);
    end
  endfunction

  // set wins over write-one-to-clear
  function [3:0] irq_next;
    input [3:0] cur;
    input [3:0] clr;
    input [3:0] evs;
    begin
      irq_next = (cur & ~clr) | evs;
    end
  endfunction

  assign fwd = fwd_s_q[1];
  assign rev = rev_s_q[1];
  assign flt = flt_s_q[1];
  assign trs = trs_s_q[1];
  assign terminal_src = (src_q == `SRC_FXRX1) || (src_q == `SRC_FXRX2);
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PWRITE;
  // refusal is judged against the inhibit already in force, not one
  // written in the same cycle
  assign bad_dir = wr && PADDR == `A_DIRCMD &&
                   inhibited(inhibit_q, PWDATA[0]);
  // a new command source must first show its stop level, unless power-up run arms a terminal source while the window is open
  assign src_change = wr && PADDR == `A_CTRL &&
                      PWDATA[2:0] <= 3'd4 && PWDATA[2:0] != src_q;
  // pending terminal run may start while the power-up window is open
  assign pwrup_arm = state_q == ST_IDLE && !trip_prev_q && pwr_run_q &&
                     terminal_src && want_run;

  always @(posedge CLK)
  begin
    fwd_s_q  <= {fwd_s_q[0], FWD_IN};
    rev_s_q  <= {rev_s_q[0], REV_IN};
    flt_s_q  <= {flt_s_q[0], FAULT};
    trs_s_q  <= {trs_s_q[0], TRIP_RESET};
    krun_s_q <= {krun_s_q[0], KEY_RUN};
    kstp_s_q <= {kstp_s_q[0], KEY_STOP};
  end

  // requested run and direction per source
  always @*
  begin
    want_run = 1'b0;
    want_rev = direction_command_param_q;
    case (src_q)
      `SRC_KEYPAD: want_run = key_latch_q;
      `SRC_FXRX1:
      begin
        want_run = fwd ^ rev;
        want_rev = rev && !fwd;
      end
      `SRC_FXRX2:
      begin
        want_run = fwd;
        want_rev = rev;
      end
      `SRC_SERIAL:
      begin
        want_run = SER_RUN;
        want_rev = SER_REV;
      end
      default: want_run = 1'b0;
    endcase
    if (inhibited(inhibit_q, want_rev))
      want_run = 1'b0;
  end

  always @*
  begin
    state_d = state_q;
    ev = 4'h0;
    case (state_q)
      ST_IDLE:
        if (flt)
        begin
          state_d = ST_TRIP;
          ev[`EV_TRIP] = 1'b1;
        end
        else if (want_run && armed_q)
          state_d = ST_RUN;
      ST_RUN:
        if (flt)
        begin
          state_d = ST_TRIP;
          ev[`EV_TRIP] = 1'b1;
        end
        else if (!want_run)
          state_d = ST_IDLE;
      ST_TRIP:
        // attempts are only cleared by a normal stop from run
        if (!flt && trs)
        begin
          if (trip_restart_enable_q && terminal_src &&
              attempts_q < restart_attempt_limit_q)
            state_d = ST_WAIT;
          else
          begin
            state_d = ST_IDLE;
            if (trip_restart_enable_q)
              ev[`EV_EXHAUST] = 1'b1;
          end
        end
      ST_WAIT:
        if (flt)
          state_d = ST_TRIP;
        else if (delay_q == 16'd0)
        begin
          state_d = want_run ? ST_RUN : ST_IDLE;
          ev[`EV_RESTART] = want_run;
        end
      default: state_d = ST_IDLE;
    endcase
    ev[`EV_REFUSED] = bad_dir;
  end

  always @(posedge CLK)
  begin
    if (SRST)
    begin
      src_q <= `SRC_KEYPAD;
      inhibit_q <= `INH_NONE;
      pwr_run_q <= 1'b0;
      trip_restart_enable_q <= 1'b0;
      speed_search_options_q <= 8'h00;
      station_id_setting_q <= `STATION_RST;
      restart_attempt_limit_q <= 4'd0;
      restart_delay_setting_q <= `DELAY_RST;
      direction_command_param_q <= 1'b0;
      attempts_q <= 4'd0;
      tick_q <= 20'd0;
      delay_q <= 16'd0;
      state_q <= ST_IDLE;
      armed_q <= 1'b0;
      key_latch_q <= 1'b0;
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
      trip_prev_q <= 1'b0;
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      DRIVE_ON <= 1'b0;
      DRIVE_REV <= 1'b0;
      SPEED_SEARCH <= 1'b0;
      IRQ <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      // after reset armed by a stop level, or with run already held only when power-up run applies
      if (!want_run)
        armed_q <= 1'b1;
      else if (pwrup_arm)
        armed_q <= 1'b1;
      if (state_q != ST_IDLE && state_d == ST_IDLE)
        armed_q <= 1'b0;
      if (state_d == ST_WAIT)
        armed_q <= 1'b0;
      if (src_change)
        armed_q <= 1'b0;

      if (krun_s_q[1])
        key_latch_q <= 1'b1;
      if (kstp_s_q[1])
        key_latch_q <= 1'b0;
      // window closes at the first terminal stop level or first exit from idle (start or trip),
      // so power-up run cannot fire again later in the session
      if ((terminal_src && !want_run) || state_q != ST_IDLE)
        trip_prev_q <= 1'b1;

      if (state_q == ST_TRIP && state_d == ST_WAIT)
      begin
        attempts_q <= attempts_q + 4'd1;
        delay_q <= restart_delay_setting_q;
        tick_q <= TICK_CYC - 20'd1;
      end
      // 100 ms ticks; a zero delay restarts on the next cycle
      else if (state_q == ST_WAIT && delay_q != 16'd0)
      begin
        if (tick_q == 20'd0)
        begin
          tick_q <= TICK_CYC - 20'd1;
          delay_q <= delay_q - 16'd1;
        end
        else
          tick_q <= tick_q - 20'd1;
      end
      if (state_q == ST_RUN && state_d == ST_IDLE)
        attempts_q <= 4'd0;
      // synchronised fault also gates the output, not only the state
      DRIVE_ON <= (state_d == ST_RUN) && !flt;
      if (state_d == ST_RUN)
        DRIVE_REV <= want_rev;
      if (state_q != ST_RUN && state_d == ST_RUN)
        SPEED_SEARCH <= (state_q == ST_WAIT) ?
          speed_search_options_q[`SS_TRIP_BIT] :
          speed_search_options_q[`SS_PWRUP_BIT];
      else if (state_d != ST_RUN)
        SPEED_SEARCH <= 1'b0;
      if (wr && PADDR == `A_IRQ_STAT)
        irq_stat_q <= irq_next(irq_stat_q, PWDATA[3:0], ev);
      else
        irq_stat_q <= irq_next(irq_stat_q, 4'h0, ev);
      IRQ <= |((irq_stat_q | ev) & irq_mask_q);
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      if (wr)
        case (PADDR)
          `A_CTRL:
          begin
            src_q <= (PWDATA[2:0] > 3'd4) ? src_q : PWDATA[2:0];
            if (PWDATA[5:4] != 2'd3)
              inhibit_q <= PWDATA[5:4];
            pwr_run_q <= PWDATA[8];
            trip_restart_enable_q <= PWDATA[9];
            speed_search_options_q <= PWDATA[23:16];
          end
          `A_STATION:
            if (PWDATA[7:0] >= `STATION_MIN &&
                PWDATA[7:0] <= `STATION_MAX)
              station_id_setting_q <= PWDATA[7:0];
          `A_RESTART:
          begin
            if (PWDATA[3:0] <= `LIMIT_MAX)
              restart_attempt_limit_q <= PWDATA[3:0];
            if (PWDATA[31:16] <= `DELAY_MAX)
              restart_delay_setting_q <= PWDATA[31:16];
          end
          `A_IRQ_MASK: irq_mask_q <= PWDATA[3:0];
          `A_DIRCMD:
            if (!bad_dir)
              direction_command_param_q <= PWDATA[0];
          `A_STATUS, `A_IRQ_STAT: ;
          default: ;
        endcase
      // read data latched at setup, stands until the next read
      if (rd && !PENABLE)
        case (PADDR)
          `A_CTRL: PRDATA <= {8'h0, speed_search_options_q, 6'h0,
                              trip_restart_enable_q, pwr_run_q, 2'h0,
                              inhibit_q, 1'b0, src_q};
          `A_STATION: PRDATA <= {24'h0, station_id_setting_q};
          `A_RESTART: PRDATA <= {restart_delay_setting_q, 12'h0,
                                 restart_attempt_limit_q};
          `A_STATUS: PRDATA <= {16'h0, attempts_q, 3'h0, armed_q,
                                2'h0, DRIVE_REV, DRIVE_ON, 2'h0,
                                state_q};
          `A_IRQ_STAT: PRDATA <= {28'h0, irq_stat_q};
          `A_IRQ_MASK: PRDATA <= {28'h0, irq_mask_q};
          `A_DIRCMD: PRDATA <= {31'h0, direction_command_param_q};
          default: PRDATA <= 32'h0;
        endcase

      // errors flagged at setup so they ride on the ready pulse
      if (PSEL && !PENABLE && !mapped(PADDR))
        PSLVERR <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** run_cmd_defines.vh ***
// constants for the run-command qualification block
`ifndef RUN_CMD_DEFINES_VH
`define RUN_CMD_DEFINES_VH
`define CLK_HZ          10000000
`define MS_CYCLES       (`CLK_HZ / 1000)
`define A_CTRL          12'h000
`define A_STATION       12'h004
`define A_RESTART       12'h008
`define A_STATUS        12'h00c
`define A_IRQ_STAT      12'h010
`define A_IRQ_MASK      12'h014
`define A_DIRCMD        12'h018
`define SRC_KEYPAD      3'd0
`define SRC_FXRX1       3'd1
`define SRC_FXRX2       3'd2
`define SRC_SERIAL      3'd3
`define INH_NONE        2'd0
`define INH_FWD         2'd1
`define INH_REV         2'd2
`define STATION_MIN     8'd1
`define STATION_MAX     8'd250
`define STATION_RST     8'd1
`define LIMIT_MAX       4'd10
`define DELAY_MAX       16'd600
`define DELAY_RST       16'd10
`define SS_TRIP_BIT     2
`define SS_PWRUP_BIT    4
`define EV_TRIP         0
`define EV_RESTART      1
`define EV_REFUSED      2
`define EV_EXHAUST      3
`endif

// *** run_cmd_ctrl_sva.sv ***
// concurrent checks on the run-command block ports
`timescale 1ns/1ps
`default_nettype none
module run_cmd_ctrl_chk
(
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        FAULT,
  input wire logic        DRIVE_ON,
  input wire logic        SPEED_SEARCH,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence access_s;
    PSEL && PENABLE && PREADY;
  endsequence
  AST_READY: assert property (setup_s |=> access_s)
    else $error("no wait-free answer");
  AST_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_HOLD: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data moved");
  AST_TRIP: assert property (FAULT |-> ##[1:4] !DRIVE_ON)
    else $error("drive kept on through fault");
  AST_START: assert property ($rose(DRIVE_ON) |-> !$past(FAULT, 4))
    else $error("start during fault");
  AST_SEARCH: assert property (SPEED_SEARCH |-> DRIVE_ON)
    else $error("search without run");
  AST_RESET: assert property (disable iff (1'b0)
    SRST |=> !DRIVE_ON && !IRQ && !PREADY)
    else $error("outputs not cleared by reset");
endmodule
bind run_cmd_ctrl run_cmd_ctrl_chk run_cmd_ctrl_chk_i (.CLK(CLK), .SRST(SRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .FAULT(FAULT), .DRIVE_ON(DRIVE_ON),
  .SPEED_SEARCH(SPEED_SEARCH), .IRQ(IRQ));
`default_nettype wire

// *** terminal_switches.sv ***
// terminal-block forward and reverse run switches
`timescale 1ns/1ps
`default_nettype none
module terminal_switches
(
  input  wire logic CLK,
  output var  logic FWD_IN,
  output var  logic REV_IN
);
  initial FWD_IN = 1'b0;
  initial REV_IN = 1'b0;
  // neither closed is a stop in both terminal sources, both closed in the SRC_FXRX1 source only; left to the drive to decode
  task set(input logic f, input logic r);
    @(posedge CLK);
    FWD_IN <= f;
    REV_IN <= r;
  endtask
endmodule
`default_nettype wire

// *** drive_run_command_control_bench.sv ***
// self-checking bench for the run-command block
`timescale 1ns/1ps
`default_nettype none
`include "run_cmd_defines.vh"
module drive_run_command_control_bench;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, fwd, rev, ser_run = 0, fault = 0, trip_reset = 0;
  logic drive_on, drive_rev, speed_search, irq;
  int n_errors = 0, check_count = 0;
  always #50 clk = ~clk;
  terminal_switches terminal_switches_i (.CLK(clk), .FWD_IN(fwd), .REV_IN(rev));
  run_cmd_ctrl run_cmd_ctrl_i (.CLK(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FWD_IN(fwd),
    .REV_IN(rev), .KEY_RUN(1'b0), .KEY_STOP(1'b0), .SER_RUN(ser_run),
    .SER_REV(1'b0), .FAULT(fault), .TRIP_RESET(trip_reset),
    .DRIVE_ON(drive_on), .DRIVE_REV(drive_rev),
    .SPEED_SEARCH(speed_search), .IRQ(irq));
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    forever
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  // settle window covers the two-stage input synchroniser
  task wt(input logic e);
    repeat (10) @(posedge clk);
    chk(drive_on, e);
  endtask
  task results;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #5000000;
    n_errors++;
    results;
  end
  initial
  begin
    terminal_switches_i.set(1, 0);
    repeat (5) @(posedge clk);
    srst <= 0;
    apb(0, `A_STATION, 0); chk(rd, 32'h1);
    apb(1, `A_STATION, 32'd251); apb(0, `A_STATION, 0); chk(rd, 32'h1);
    apb(1, `A_STATION, 32'd250); apb(0, `A_STATION, 0); chk(rd, 32'hfa);
    apb(0, 12'hffc, 0); chk(er, 1'b1);
    apb(1, `A_CTRL, 32'h1); wt(0);
    terminal_switches_i.set(0, 0); wt(0);
    terminal_switches_i.set(1, 0); wt(1);
    terminal_switches_i.set(1, 1); wt(0);
    terminal_switches_i.set(0, 1); wt(1); chk(drive_rev, 1'b1);
    terminal_switches_i.set(0, 0);
    apb(1, `A_CTRL, 32'h21); apb(1, `A_IRQ_MASK, 32'h4);
    apb(1, `A_DIRCMD, 32'h1); wt(0); chk(irq, 1'b1);
    apb(0, `A_DIRCMD, 0); chk(rd & 32'h1, 32'h0);
    apb(1, `A_IRQ_STAT, 32'h4); wt(0); chk(irq, 1'b0);
    apb(1, `A_CTRL, 32'h1); terminal_switches_i.set(1, 0); wt(1);
    @(posedge clk) fault <= 1; wt(0);
    @(posedge clk) fault <= 0; trip_reset <= 1; wt(0);
    @(posedge clk) trip_reset <= 0;
    apb(1, `A_CTRL, 32'h40201); apb(1, `A_RESTART, 32'h1);
    terminal_switches_i.set(0, 0); wt(0);
    terminal_switches_i.set(1, 0); wt(1); chk(speed_search, 1'b0);
    @(posedge clk) fault <= 1; wt(0);
    @(posedge clk) fault <= 0; trip_reset <= 1; wt(1);
    chk(speed_search, 1'b1);
    @(posedge clk) trip_reset <= 0;
    @(posedge clk) fault <= 1; wt(0);
    @(posedge clk) fault <= 0; trip_reset <= 1; wt(0);
    @(posedge clk) trip_reset <= 0;
    apb(0, `A_IRQ_STAT, 0); chk(rd, 32'hb);
    apb(1, `A_CTRL, 32'h3); wt(0);
    @(posedge clk) ser_run <= 1; wt(1);
    terminal_switches_i.set(1, 0);
    @(posedge clk) srst <= 1;
    repeat (5) @(posedge clk);
    srst <= 0;
    chk(drive_on, 1'b0);
    apb(1, `A_CTRL, 32'h100101); wt(1);
    chk(speed_search, 1'b1);
    results;
  end
endmodule
`default_nettype wire
